// File: design/tec_bank.v
/*
 * configuration and boundary register bank with the event output logic.
 * assumes the serial bus engine outside presents a register pointer,
 * write data and a write strobe as level signals from its own clock
 * domain; the strobe is synchronised and its rising edge commits the
 * write. read data is combinational on the staged pointer, then registered.
 */
`timescale 1ns/1ns
`include "tec_regs.vh"

module tec_bank (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // register access from the serial bus engine
    input wire [7:0] reg_ptr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    output reg [15:0] reg_rdata,
    // converter sample
    input wire [15:0] adc_sample,
    input wire adc_valid,
    // event pin
    output reg event_out,
    output reg event_oe,
    // state
    output reg power_down_select
);
    // ------------------------------------------------------------
    // synchronised inputs
    // ------------------------------------------------------------
    wire wr_sync;
    wire adc_valid_sync;
    reg wr_prev;
    reg adc_prev;
    wire wr_go;
    wire adc_go;

    tec_sync u_sync_wr (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(reg_wr),
        .dout(wr_sync)
    );

    tec_sync u_sync_adc (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(adc_valid),
        .dout(adc_valid_sync)
    );

    always @(posedge clk_sys) begin
        if (rst) begin
            wr_prev <= 1'b0;
            adc_prev <= 1'b0;
        end else begin
            wr_prev <= wr_sync;
            adc_prev <= adc_valid_sync;
        end
    end

    assign wr_go = wr_sync & ~wr_prev;
    assign adc_go = adc_valid_sync & ~adc_prev;

    // ------------------------------------------------------------
    // bus and sample levels, two stages each
    // ------------------------------------------------------------
    reg [7:0] ptr_meta;
    reg [7:0] ptr_s;
    reg [15:0] wdata_meta;
    reg [15:0] wdata_s;
    reg [15:0] sample_meta;
    reg [15:0] sample_s;

    // the engine holds these from its strobe edge on, so the staged
    // copies have settled by the time the synchronised edge fires
    always @(posedge clk_sys) begin
        if (rst) begin
            ptr_meta <= 8'h00;
            ptr_s <= 8'h00;
            wdata_meta <= 16'h0000;
            wdata_s <= 16'h0000;
            sample_meta <= 16'h0000;
            sample_s <= 16'h0000;
        end else begin
            ptr_meta <= reg_ptr;
            ptr_s <= ptr_meta;
            wdata_meta <= reg_wdata;
            wdata_s <= wdata_meta;
            sample_meta <= adc_sample;
            sample_s <= sample_meta;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [1:0] hyst;
    reg crit_lock;
    reg win_lock;
    reg ev_en;
    reg ev_sel;
    reg ev_pol;
    reg ev_mode;
    reg [15:0] upper_boundary_limit;
    reg [15:0] lower_boundary_limit;
    reg [15:0] critical_boundary_limit;
    reg [15:0] ambient_reading;
    reg int_flag;
    reg ev_active;
    wire any_lock;
    wire wr_cfg;
    wire iclr;

    assign any_lock = crit_lock | win_lock;
    assign wr_cfg = wr_go && (ptr_s == `TEC_PTR_CONFIG);
    assign iclr = wr_cfg && wdata_s[`TEC_CFG_ICLR];

    always @(posedge clk_sys) begin
        if (rst) begin
            hyst <= 2'h0;
            power_down_select <= 1'b0;
            crit_lock <= 1'b0;
            win_lock <= 1'b0;
            ev_en <= 1'b0;
            ev_sel <= 1'b0;
            ev_pol <= 1'b0;
            ev_mode <= 1'b0;
        end else if (wr_cfg) begin
            // fields stay writable in power-down: no shutdown gating; a lock blocks setting power-down but not clearing it
            if (!any_lock) begin
                hyst <= wdata_s[`TEC_CFG_HYST_HI:`TEC_CFG_HYST_LO];
                ev_en <= wdata_s[`TEC_CFG_EN];
                ev_pol <= wdata_s[`TEC_CFG_POL];
                ev_mode <= wdata_s[`TEC_CFG_MODE];
            end
            if (!win_lock)
                ev_sel <= wdata_s[`TEC_CFG_SEL];
            if (!any_lock || !wdata_s[`TEC_CFG_PDOWN])
                power_down_select <= wdata_s[`TEC_CFG_PDOWN];
            // locks are sticky until reset
            if (wdata_s[`TEC_CFG_CLOCK])
                crit_lock <= 1'b1;
            if (wdata_s[`TEC_CFG_WLOCK])
                win_lock <= 1'b1;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            upper_boundary_limit <= `TEC_LIMIT_RESET;
            lower_boundary_limit <= `TEC_LIMIT_RESET;
            critical_boundary_limit <= `TEC_LIMIT_RESET;
        end else if (wr_go) begin
            // unused bits stored as zero
            if (ptr_s == `TEC_PTR_UPPER && !win_lock)
                upper_boundary_limit <= wdata_s & `TEC_LIMIT_MASK;
            if (ptr_s == `TEC_PTR_LOWER && !win_lock)
                lower_boundary_limit <= wdata_s & `TEC_LIMIT_MASK;
            if (ptr_s == `TEC_PTR_CRIT && !crit_lock)
                critical_boundary_limit <= wdata_s & `TEC_LIMIT_MASK;
        end
    end

    // conversion halts in power-down; last reading is kept
    always @(posedge clk_sys) begin
        if (rst)
            ambient_reading <= 16'h0000;
        else if (adc_go && !power_down_select)
            ambient_reading <= sample_s & `TEC_AMB_MASK;
    end

    // ------------------------------------------------------------
    // event condition
    // ------------------------------------------------------------
    wire above_crit;
    wire above_upper;
    wire below_lower;
    wire cond;

    tec_cmp u_cmp (
        .ambient_reading(ambient_reading),
        .upper_boundary_limit(upper_boundary_limit),
        .lower_boundary_limit(lower_boundary_limit),
        .critical_boundary_limit(critical_boundary_limit),
        .above_crit(above_crit),
        .above_upper(above_upper),
        .below_lower(below_lower)
    );

    assign cond = above_crit |
                  (~ev_sel & (above_upper | below_lower));

    // interrupt flag: clear beats set; a clear in power-down takes effect
    // at once because power-down does not gate the flag, which is simply dropped
    always @(posedge clk_sys) begin
        if (rst)
            int_flag <= 1'b0;
        else if (ev_mode && ev_en && cond && !int_flag && !iclr)
            int_flag <= 1'b1;
        else if (iclr)
            int_flag <= 1'b0;
        else if (!ev_mode)
            int_flag <= 1'b0;
    end

    // critical crossing always shows in interrupt mode too
    always @(posedge clk_sys) begin
        if (rst)
            ev_active <= 1'b0;
        else
            ev_active <= ev_en && !power_down_select &&
                (ev_mode ? (int_flag || above_crit) : cond);
    end

    // ------------------------------------------------------------
    // pin and read data
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            event_out <= 1'b1;
            event_oe <= 1'b0;
        end else begin
            // open-drain style when active low: drive only the active level; active high drives always
            // power-down gates here too so pin and status drop together
            event_out <= ev_pol ? (ev_active & ~power_down_select) :
                ~(ev_active & ~power_down_select);
            event_oe <= ev_pol ? 1'b1 : (ev_active & ~power_down_select);
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            case (ptr_s)
                `TEC_PTR_CONFIG:
                    // status mirrors the asserted pin; clear reads 0
                    reg_rdata <= {5'h00, hyst, power_down_select,
                        crit_lock, win_lock, 1'b0,
                        ev_active & ~power_down_select,
                        ev_en, ev_sel, ev_pol, ev_mode};
                `TEC_PTR_UPPER: reg_rdata <= upper_boundary_limit;
                `TEC_PTR_LOWER: reg_rdata <= lower_boundary_limit;
                `TEC_PTR_CRIT: reg_rdata <= critical_boundary_limit;
                `TEC_PTR_AMBIENT:
                    reg_rdata <= {above_crit, above_upper, below_lower,
                        ambient_reading[12:0]};
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule

// File: design/tec_regs.vh
/*
 * register pointers, field positions, reset values and timing counts
 * for the thermal event configuration and boundary register bank.
 * assumes inclusion by bare name from the design files.
 */
`ifndef TEC_REGS_VH
`define TEC_REGS_VH

// ----------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------
`define TEC_PTR_CONFIG 8'h01
`define TEC_PTR_UPPER 8'h02
`define TEC_PTR_LOWER 8'h03
`define TEC_PTR_CRIT 8'h04
`define TEC_PTR_AMBIENT 8'h05

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define TEC_CFG_MODE 0
`define TEC_CFG_POL 1
`define TEC_CFG_SEL 2
`define TEC_CFG_EN 3
`define TEC_CFG_STAT 4
`define TEC_CFG_ICLR 5
`define TEC_CFG_WLOCK 6
`define TEC_CFG_CLOCK 7
`define TEC_CFG_PDOWN 8
`define TEC_CFG_HYST_LO 9
`define TEC_CFG_HYST_HI 10

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define TEC_CONFIG_RESET 16'h0000
`define TEC_LIMIT_RESET 16'h0000
`define TEC_LIMIT_MASK 16'h1ffc
`define TEC_AMB_MASK 16'h1fff

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TEC_CLK_NS 10
`define TEC_WR_HOLD_NS 20
`define TEC_WR_HOLD_CYC ((`TEC_WR_HOLD_NS + `TEC_CLK_NS - 1) / `TEC_CLK_NS)

`endif

// File: design/tec_sync.v
/*
 * two flip-flop synchroniser for one level from outside the clock domain.
 * assumes clk_sys and a synchronous active high reset.
 */
`timescale 1ns/1ns
module tec_sync (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // level
    input wire din,
    output reg dout
);
    reg stage1;

    always @(posedge clk_sys) begin
        if (rst) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// File: design/tec_cmp.v
/*
 * signed boundary comparisons of the ambient reading against the limits.
 * assumes 13-bit two's complement values in bits 12..0, same scale.
 */
`timescale 1ns/1ns
module tec_cmp (
    // values
    input wire [15:0] ambient_reading,
    input wire [15:0] upper_boundary_limit,
    input wire [15:0] lower_boundary_limit,
    input wire [15:0] critical_boundary_limit,
    // results
    output wire above_crit,
    output wire above_upper,
    output wire below_lower
);
    function signed [12:0] tval;
        input [15:0] v;
        begin
            tval = v[12:0];
        end
    endfunction

    assign above_crit = tval(ambient_reading) >=
                        tval(critical_boundary_limit);
    assign above_upper = tval(ambient_reading) > tval(upper_boundary_limit);
    assign below_lower = tval(ambient_reading) < tval(lower_boundary_limit);
endmodule

// File: test/tec_bank_props.sv
/*
 * assertions on the ports of the event configuration and limit bank.
 * assumes one clock domain and a synchronous active high reset.
 */
`timescale 1ns/1ns
module tec_bank_props (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // register access
    input wire [7:0] reg_ptr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire [15:0] reg_rdata,
    // converter
    input wire [15:0] adc_sample,
    input wire adc_valid,
    // event pin and state
    input wire event_out,
    input wire event_oe,
    input wire power_down_select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // read data trails the pointer by its two stages plus the register
    reg [7:0] ptr_q1, ptr_q2, ptr_q3;
    always @(posedge clk_sys) begin
        ptr_q1 <= reg_ptr;
        ptr_q2 <= ptr_q1;
        ptr_q3 <= ptr_q2;
    end
    wire settled = reg_ptr == ptr_q1 && ptr_q1 == ptr_q2 &&
        ptr_q2 == ptr_q3;
    wire cfg_rd = reg_ptr == 8'h01 && settled;
    property p_stat_pin;
        cfg_rd && $past(cfg_rd) |->
            reg_rdata[4] == (reg_rdata[1] ? event_out : !event_out);
    endproperty
    a_stat_pin: assert property (p_stat_pin) else $error("status vs pin");
    property p_stat_pd;
        cfg_rd && power_down_select |=> reg_rdata[4] == 1'b0;
    endproperty
    a_stat_pd: assert property (p_stat_pd) else $error("status in pd");
    property p_oe;
        cfg_rd && $past(cfg_rd) |->
            event_oe == (reg_rdata[1] || !event_out);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_pd_pin;
        (cfg_rd && power_down_select)[*3] |->
            !(event_oe && event_out == reg_rdata[1]);
    endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("pin set in pd");
    property p_lim_zero;
        reg_ptr inside {8'h02, 8'h03, 8'h04} && settled |->
            (reg_rdata & 16'he003) == 16'h0000;
    endproperty
    a_lim_zero: assert property (p_lim_zero) else $error("limit pad");
    property p_cfg_zero;
        cfg_rd |-> (reg_rdata & 16'hf820) == 16'h0000;
    endproperty
    a_cfg_zero: assert property (p_cfg_zero) else $error("config pad");
    property p_unmapped;
        reg_ptr > 8'h05 && settled |-> reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_lock_fields;
        cfg_rd && $past(cfg_rd) && $past(cfg_rd, 2) &&
            $past(reg_rdata[6] || reg_rdata[7]) |->
            (reg_rdata & 16'h000b) == ($past(reg_rdata) & 16'h000b);
    endproperty
    a_lock_fields: assert property (p_lock_fields) else $error("lock");
    property p_sel_lock;
        cfg_rd && $past(cfg_rd) && $past(cfg_rd, 2) && $past(reg_rdata[6])
            |-> reg_rdata[2] == $past(reg_rdata[2]);
    endproperty
    a_sel_lock: assert property (p_sel_lock) else $error("sel lock");
    c_write: cover property ($rose(reg_wr));
    c_pdown: cover property ($rose(power_down_select));
    c_event: cover property (event_oe && event_out);
endmodule

bind tec_bank tec_bank_props u_props (.clk_sys(clk_sys), .rst(rst),
    .reg_ptr(reg_ptr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .adc_sample(adc_sample), .adc_valid(adc_valid),
    .event_out(event_out), .event_oe(event_oe),
    .power_down_select(power_down_select));

// File: test/tec_host.sv
/*
 * host model: serial bus engine levels paced by the link clock.
 * assumes the bench supplies the link clock.
 */
`timescale 1ns/1ns
module tec_host (
    // link clock
    input wire clk_link,
    // register access
    output logic [7:0] reg_ptr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    input wire [15:0] reg_rdata
);
    initial begin
        reg_ptr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
    end
    // data turns over once its hold has run out
    task wr(input logic [7:0] p, input logic [15:0] d);
        @(posedge clk_link);
        reg_ptr = p;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_link);
        reg_wr = 1'b0;
        @(posedge clk_link);
        reg_wdata = ~d;
    endtask
    task rd(input logic [7:0] p, output logic [15:0] d);
        @(posedge clk_link);
        reg_ptr = p;
        @(posedge clk_link);
        d = reg_rdata;
    endtask
endmodule

// File: test/tb.sv
/*
 * self-checking bench for the event configuration and limit bank.
 * assumes the host model drives register levels on a 125 ns link clock.
 */
`timescale 1ns/1ns
module tb;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic rst = 1'b1;
    logic [15:0] adc_sample = 16'h0000;
    logic adc_valid = 1'b0;
    wire [7:0] reg_ptr;
    wire [15:0] reg_wdata, reg_rdata;
    wire reg_wr, event_out, event_oe, power_down_select;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 clk_sys = ~clk_sys;
    always begin
        #62 clk_link = 1'b1;
        #63 clk_link = 1'b0;
    end
    tec_bank DUT (.clk_sys(clk_sys), .rst(rst), .reg_ptr(reg_ptr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .adc_sample(adc_sample), .adc_valid(adc_valid),
        .event_out(event_out), .event_oe(event_oe),
        .power_down_select(power_down_select));
    tec_host host (.clk_link(clk_link), .reg_ptr(reg_ptr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata));
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd(input logic [7:0] p, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(p, d);
        chk(d, exp);
    endtask
    // pin as {event_out, event_oe}
    task pin(input logic [1:0] e);
        chk({14'h0000, event_out, event_oe}, {14'h0000, e});
    endtask
    task amb(input logic [15:0] v);
        @(posedge clk_sys);
        adc_sample <= v;
        adc_valid <= 1'b1;
        repeat (6) @(posedge clk_sys);
        adc_valid <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h01, 16'h0000);
        rd(8'h04, 16'h0000);
        rd(8'h06, 16'h0000);
        pin(2'b10);
        host.wr(8'h02, 16'hffff);
        rd(8'h02, 16'h1ffc);
        host.wr(8'h02, 16'h0190);
        host.wr(8'h03, 16'h0050);
        host.wr(8'h04, 16'h0320);
        rd(8'h03, 16'h0050);
        amb(16'h00c8);
        host.wr(8'h01, 16'h0008);
        rd(8'h01, 16'h0008);
        amb(16'h01e0);
        pin(2'b01);
        rd(8'h01, 16'h0018);
        amb(16'h0020);
        pin(2'b01);
        amb(16'h00c8);
        pin(2'b10);
        host.wr(8'h01, 16'h000c);
        amb(16'h01e0);
        pin(2'b10);
        amb(16'h0320);
        pin(2'b01);
        host.wr(8'h01, 16'h000a);
        amb(16'h00c8);
        pin(2'b01);
        amb(16'h01e0);
        pin(2'b11);
        host.wr(8'h01, 16'h0009);
        amb(16'h00c8);
        pin(2'b01);
        host.wr(8'h01, 16'h0029);
        pin(2'b10);
        rd(8'h01, 16'h0009);
        host.wr(8'h01, 16'h0008);
        amb(16'h01e0);
        host.wr(8'h01, 16'h0108);
        pin(2'b10);
        rd(8'h01, 16'h0108);
        host.wr(8'h01, 16'h010a);
        rd(8'h01, 16'h010a);
        pin(2'b01);
        host.wr(8'h01, 16'h000a);
        pin(2'b11);
        host.wr(8'h01, 16'h004a);
        host.wr(8'h02, 16'h0000);
        rd(8'h02, 16'h0190);
        host.wr(8'h01, 16'h0045);
        rd(8'h01, 16'h005a);
        host.wr(8'h04, 16'h0400);
        rd(8'h04, 16'h0400);
        host.wr(8'h01, 16'h01ca);
        host.wr(8'h04, 16'h0100);
        rd(8'h04, 16'h0400);
        host.wr(8'h01, 16'h0000);
        rd(8'h01, 16'h00da);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h01, 16'h0000);
        host.wr(8'h01, 16'h0004);
        rd(8'h01, 16'h0004);
        stop_test;
    end
endmodule
